// *** design/amm_mixer.sv ***
// mixing matrix: 36 sources to 18 outputs with routing gains, metering and record path
// Function
// - 18 hardware inputs, 18 playback channels and 18 outputs are the routing ends.
// - nine independent stereo submixes, each with its own source gains.
// - every source-to-submix routing has its own gain, shared by the pair's two outputs; no shared channel fader.
// - one input can feed any number of outputs at different levels.
// - record path carries inputs untouched, except outputs set to loopback.
// - every input, playback and output channel has peak and rms meters.
// - source meters tap the signal before routing gain.
// - output meters tap the signal after gain.
// - peak detector has zero attack; one full-scale sample registers.
// - rms is a true square root of a slow running mean square.
// - overload on a metered channel sets its over flag.
// - level readout refreshes twice a second, peak or rms selectable.
// - pan splits between left and right, 3 dB down at centre.
// - each source has mute and solo.
// - channels run mono or as adjacent stereo pairs.
// - a routing with gain off counts as inactive.
// - in trim mode a gain change moves every active routing of the channel.
// - trim control shows highest routing gain; routings keep relative spacing.
// - outside trim mode, active grouped routing gains all move by the same relative amount.
// - each output has its own level scaling its whole submix.
`timescale 1ns/1ps
module amm_mixer
  import amm_pkg::*;
#(
  parameter int REFRESH_CYCLES = REFRESH_CYC,
  parameter int RMS_K = RMS_SHIFT
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic smp_valid,
  input wire amm_smp_t [N_HW-1:0] hw_in,
  input wire amm_smp_t [N_PB-1:0] pb_in,
  input wire amm_chan_s [N_SRC-1:0] chan_cfg,
  input wire logic [N_SRC/2-1:0] stereo_src,
  input wire logic [N_OUT-1:0][GW-1:0] out_level,
  input wire logic [N_OUT-1:0] loopback,
  input wire logic cmd_valid,
  input wire amm_cmd_s cmd,
  output logic cmd_ready,
  output logic cmd_ack,
  output logic [GW-1:0] ctrl_gain,
  output amm_smp_t [N_OUT-1:0] out_data,
  output logic out_valid,
  output amm_smp_t [N_HW-1:0] rec_data,
  output logic rec_valid,
  input wire logic [5:0] meter_sel,
  input wire logic meter_rms,
  input wire logic [N_MET-1:0] ovr_clear,
  output logic [SW-1:0] level,
  output logic level_valid,
  output logic [N_MET-1:0] overload_indicator
);
  typedef enum {ST_IDLE, ST_MIX, ST_OUTG, ST_SCAN, ST_APPLY} amm_state_e;
  localparam logic signed [AW-1:0] Y_MAX = AW'(signed'(FS_POS));
  localparam logic signed [AW-1:0] Y_MIN = ~Y_MAX;

  amm_state_e st_r;
  amm_smp_t [N_SRC-1:0] smp_r;
  amm_chan_s [N_SRC-1:0] cfg_a_r;
  logic [N_SRC/2-1:0] stereo_a_r;
  logic [N_OUT-1:0][GW-1:0] lvl_a_r;
  logic [N_OUT-1:0] loop_a_r;
  logic [GW-1:0] gain_r [N_SRC][N_PAIR];
  logic grp_r [N_SRC][N_PAIR];
  logic [SW-1:0] peak_r [N_MET];
  logic [2*SW-1:0] ms_r [N_MET];
  logic [5:0] s_r;
  logic [4:0] d_r;
  logic [3:0] p_r;
  logic signed [AW-1:0] acc_r;
  logic pend_r;
  amm_cmd_s cmd_r;
  logic [GW-1:0] max_r;
  logic [GW-1:0] nmax_r;
  logic signed [9:0] delta_r;
  logic trim_on_r;
  logic cmd_ready_r;
  logic cmd_ack_r;
  logic [GW-1:0] ctrl_gain_r;
  amm_smp_t [N_OUT-1:0] out_r;
  logic out_valid_r;
  amm_smp_t [N_HW-1:0] rec_r;
  logic rec_valid_r;
  logic [31:0] ref_cnt_r;
  logic [SW-1:0] level_r;
  logic level_valid_r;
  logic [N_MET-1:0] ovr_r;

  logic start_mix;
  logic take_cmd;
  logic any_solo;
  logic side;
  logic st_src;
  logic route;
  logic muted;
  logic [5:0] base_s;
  amm_chan_s bc;
  logic [4:0] pdist;
  logic [GW-1:0] g_raw;
  logic [GW-1:0] att;
  logic [GW-1:0] eff;
  logic signed [AW-1:0] prod;
  logic signed [AW-1:0] y_full;
  amm_smp_t y_sat;
  logic met_wr;
  logic [5:0] met_i;
  amm_smp_t met_v;
  logic [SW-1:0] met_abs;
  logic tick;
  logic [GW-1:0] g_cur;
  logic [GW-1:0] g_new;
  logic [GW-1:0] g_shift;
  logic signed [9:0] g_sum;
  logic is_tgt;

  // a sample arriving while the mix runs is dropped: the mix must finish within one sample period
  assign start_mix = (st_r == ST_IDLE) && (pend_r || smp_valid);
  assign take_cmd = cmd_valid && cmd_ready_r && !start_mix;
  assign any_solo = solo_any(cfg_a_r);
  assign tick = (ref_cnt_r == 32'(REFRESH_CYCLES - 1));

  function automatic logic solo_any(input amm_chan_s [N_SRC-1:0] c);
    logic r;
    r = 1'b0;
    for (int i = 0; i < N_SRC; i++) r = r | c[i].solo;
    return r;
  endfunction : solo_any

  // routing term for source s_r into output d_r
  always_comb begin
    side = d_r[0];
    st_src = stereo_a_r[s_r[5:1]];
    base_s = st_src ? {s_r[5:1], 1'b0} : s_r;
    route = !st_src || (s_r[0] == side);
    bc = cfg_a_r[base_s];
    muted = bc.mute || (any_solo && !bc.solo);
    g_raw = gain_r[base_s][d_r[4:1]];
    pdist = side ? PAN_FULL - bc.pan : bc.pan;
    att = amm_pan_att(pdist);
    eff = (!route || muted || g_raw <= att) ? GAIN_OFF : g_raw - att;
    prod = amm_gain_mul(AW'(smp_r[s_r]), eff);
    y_full = amm_gain_mul(acc_r, lvl_a_r[d_r]);
    if (y_full > Y_MAX) y_sat = FS_POS;
    else if (y_full < Y_MIN) y_sat = ~FS_POS;
    else y_sat = y_full[SW-1:0];
  end

  // sources metered pre-gain on the first output pass, outputs post-gain
  always_comb begin
    met_wr = (st_r == ST_MIX && d_r == '0) || st_r == ST_OUTG;
    met_i = (st_r == ST_MIX) ? s_r : 6'(N_SRC) + 6'(d_r);
    met_v = (st_r == ST_MIX) ? smp_r[s_r] : y_sat;
    met_abs = met_v[SW-1] ? ~met_v + 1'b1 : met_v;
  end

  // command walk: trim shifts active routings, groups shift grouped ones
  always_comb begin
    g_cur = gain_r[s_r][p_r[3:0]];
    is_tgt = (s_r == cmd_r.src) && (p_r == cmd_r.pair);
    g_sum = 10'(g_cur) + delta_r;
    // signed bounds: an unsigned compare would push a negative sum up to the top code
    if (g_sum < signed'(10'(GAIN_MIN))) g_shift = GAIN_MIN;
    else if (g_sum > signed'(10'(GAIN_MAX))) g_shift = GAIN_MAX;
    else g_shift = g_sum[GW-1:0];
    if (g_cur == GAIN_OFF) g_shift = GAIN_OFF;
    g_new = g_cur;
    if (cmd_r.op == OP_GAIN) begin
      if (trim_on_r) begin
        if (s_r == cmd_r.src) g_new = g_shift;
      end else if (is_tgt) begin
        g_new = cmd_r.val;
      end else if (grp_r[cmd_r.src][cmd_r.pair] && grp_r[s_r][p_r]) begin
        g_new = g_shift;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
      s_r <= '0;
      d_r <= '0;
      p_r <= '0;
      acc_r <= '0;
      max_r <= GAIN_OFF;
      nmax_r <= GAIN_OFF;
      delta_r <= '0;
      trim_on_r <= 1'b0;
      cmd_r <= '0;
      cmd_ack_r <= 1'b0;
      ctrl_gain_r <= GAIN_OFF;
      out_valid_r <= 1'b0;
    end else begin
      cmd_ack_r <= 1'b0;
      out_valid_r <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          s_r <= '0;
          d_r <= '0;
          p_r <= '0;
          acc_r <= '0;
          if (start_mix) begin
            st_r <= ST_MIX;
          end else if (take_cmd) begin
            cmd_r <= cmd;
            max_r <= GAIN_OFF;
            st_r <= ST_SCAN;
          end
        end
        ST_MIX: begin
          acc_r <= acc_r + prod;
          if (s_r == 6'(N_SRC - 1)) st_r <= ST_OUTG;
          else s_r <= s_r + 6'h01;
        end
        ST_OUTG: begin
          acc_r <= '0;
          s_r <= '0;
          if (d_r == 5'(N_OUT - 1)) begin
            d_r <= '0;
            out_valid_r <= 1'b1;
            st_r <= ST_IDLE;
          end else begin
            d_r <= d_r + 5'h01;
            st_r <= ST_MIX;
          end
        end
        ST_SCAN: begin
          if (gain_r[cmd_r.src][p_r] > max_r) max_r <= gain_r[cmd_r.src][p_r];
          if (p_r == 4'(N_PAIR - 1)) begin
            trim_on_r <= cfg_a_r[cmd_r.src].trim && (max_r != GAIN_OFF || gain_r[cmd_r.src][p_r] != GAIN_OFF);
            delta_r <= 10'(cmd_r.val) - ((cfg_a_r[cmd_r.src].trim)
              ? 10'((gain_r[cmd_r.src][p_r] > max_r) ? gain_r[cmd_r.src][p_r] : max_r)
              : 10'(gain_r[cmd_r.src][cmd_r.pair]));
            p_r <= '0;
            s_r <= '0;
            nmax_r <= GAIN_OFF;
            st_r <= ST_APPLY;
          end else begin
            p_r <= p_r + 4'h1;
          end
        end
        ST_APPLY: begin
          if (s_r == cmd_r.src && g_new > nmax_r) nmax_r <= g_new;
          if (p_r == 4'(N_PAIR - 1)) begin
            p_r <= '0;
            if (s_r == 6'(N_SRC - 1)) begin
              s_r <= '0;
              cmd_ack_r <= 1'b1;
              ctrl_gain_r <= (s_r == cmd_r.src && g_new > nmax_r) ? g_new : nmax_r;
              st_r <= ST_IDLE;
            end else begin
              s_r <= s_r + 6'h01;
            end
          end else begin
            p_r <= p_r + 4'h1;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // sample capture and settings latch; settings only change when a mix starts
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      smp_r <= '0;
      pend_r <= 1'b0;
      cfg_a_r <= '0;
      stereo_a_r <= '0;
      lvl_a_r <= '0;
      loop_a_r <= '0;
      cmd_ready_r <= 1'b0;
    end else begin
      cmd_ready_r <= (st_r == ST_IDLE) && !start_mix && !take_cmd;
      if (smp_valid && st_r != ST_MIX && st_r != ST_OUTG) smp_r <= {pb_in, hw_in};
      if (start_mix) begin
        pend_r <= 1'b0;
        cfg_a_r <= chan_cfg;
        stereo_a_r <= stereo_src;
        lvl_a_r <= out_level;
        loop_a_r <= loopback;
      end else if (smp_valid && st_r != ST_MIX && st_r != ST_OUTG) begin
        pend_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < N_SRC; i++) begin
        for (int j = 0; j < N_PAIR; j++) begin
          gain_r[i][j] <= GAIN_OFF;
          grp_r[i][j] <= 1'b0;
        end
      end
    end else if (st_r == ST_APPLY) begin
      gain_r[s_r][p_r] <= g_new;
      if (is_tgt && cmd_r.op == OP_GROUP) grp_r[s_r][p_r] <= cmd_r.val[0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_r <= '0;
      rec_r <= '0;
      rec_valid_r <= 1'b0;
    end else begin
      rec_valid_r <= 1'b0;
      if (st_r == ST_OUTG) out_r[d_r] <= y_sat;
      if (st_r == ST_OUTG && d_r == 5'(N_OUT - 1)) begin
        rec_valid_r <= 1'b1;
        for (int i = 0; i < N_HW; i++) begin
          rec_r[i] <= loop_a_r[i] ? ((i == N_OUT - 1) ? y_sat : out_r[i]) : smp_r[i];
        end
      end
    end
  end

  // peak window restarts at each readout; a capture in that cycle still lands
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < N_MET; i++) begin
        peak_r[i] <= '0;
        ms_r[i] <= '0;
      end
      ovr_r <= '0;
    end else begin
      if (tick) begin
        for (int i = 0; i < N_MET; i++) peak_r[i] <= '0;
      end
      ovr_r <= ovr_r & ~ovr_clear;
      if (met_wr) begin
        if (tick || met_abs > peak_r[met_i]) peak_r[met_i] <= met_abs;
        // square at full width: a self-sized product would lose its top half
        ms_r[met_i] <= ms_r[met_i] + (2*SW)'((signed'({1'b0, (2*SW)'(met_abs) * (2*SW)'(met_abs)})
                       - signed'({1'b0, ms_r[met_i]})) >>> RMS_K);
        if (met_abs >= FS_POS) ovr_r[met_i] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ref_cnt_r <= '0;
      level_r <= '0;
      level_valid_r <= 1'b0;
    end else begin
      ref_cnt_r <= tick ? '0 : ref_cnt_r + 32'h0000_0001;
      level_valid_r <= tick;
      if (tick) begin
        if (meter_sel >= 6'(N_MET)) level_r <= '0;
        else level_r <= meter_rms ? amm_isqrt(ms_r[meter_sel]) : peak_r[meter_sel];
      end
    end
  end

  assign cmd_ready = cmd_ready_r;
  assign cmd_ack = cmd_ack_r;
  assign ctrl_gain = ctrl_gain_r;
  assign out_data = out_r;
  assign out_valid = out_valid_r;
  assign rec_data = rec_r;
  assign rec_valid = rec_valid_r;
  assign level = level_r;
  assign level_valid = level_valid_r;
  assign overload_indicator = ovr_r;

  localparam int MIX_CYC = N_OUT * (N_SRC + 1) + 1;
  logic [9:0] mix_cnt_r;

  // cycles since the mix start edge; the latency is too long for a plain delay
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mix_cnt_r <= '0;
    end else if (start_mix) begin
      mix_cnt_r <= 10'h001;
    end else if (st_r == ST_MIX || st_r == ST_OUTG) begin
      mix_cnt_r <= mix_cnt_r + 10'h001;
    end else begin
      mix_cnt_r <= '0;
    end
  end

  chk_mix_latency: assert property (@(posedge clk_sys) disable iff (!rst_n)
    out_valid_r == (mix_cnt_r == 10'(MIX_CYC))) else $error("mix latency off");
  chk_cfg_frozen: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_r != ST_IDLE) |=> $stable(cfg_a_r) && $stable(lvl_a_r)) else $error("settings moved mid-sample");
  chk_mute_silent: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_r == ST_MIX && muted) |=> acc_r == $past(acc_r)) else $error("muted source reached the sum");
  chk_inactive_route: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_r == ST_APPLY && g_cur == GAIN_OFF && !is_tgt) |-> g_new == GAIN_OFF) else $error("inactive routing moved");
  chk_peak_attack: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (met_wr && met_abs >= FS_POS) |=> peak_r[$past(met_i)] >= FS_POS) else $error("full-scale peak missed");
  chk_over_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (met_wr && met_abs >= FS_POS) |=> overload_indicator[$past(met_i)]) else $error("over not flagged");
  chk_level_rate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    level_valid_r |=> !level_valid_r [*2]) else $error("readout refreshed too often");
  chk_record_path: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (rec_valid_r && !loop_a_r[0]) |-> rec_r[0] == smp_r[0]) else $error("record data altered");
  chk_sat_clip: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_r == ST_OUTG && y_full > Y_MAX) |=> out_r[$past(d_r)] == FS_POS) else $error("output wrapped");
  chk_cmd_ready: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_r != ST_IDLE) |-> !cmd_ready_r) else $error("command ready while busy");
endmodule : amm_mixer

// *** design/amm_pkg.sv ***
// package: constants, types and arithmetic helpers of the audio mixing matrix
package amm_pkg;
  localparam int N_HW = 18;
  localparam int N_PB = 18;
  localparam int N_SRC = N_HW + N_PB;
  localparam int N_OUT = 18;
  localparam int N_PAIR = N_OUT / 2;
  localparam int N_MET = N_SRC + N_OUT;
  localparam int SW = 24;
  localparam int AW = 40;
  localparam int GW = 8;
  localparam int CLK_HZ = 10_000_000;
  localparam int REFRESH_MS = 500;
  localparam int REFRESH_CYC = CLK_HZ / 1000 * REFRESH_MS;
  localparam int RMS_SHIFT = 12;
  localparam int UNITY_SHIFT = 45;
  // gain code: 0 is off, each step 0.75 dB, unity at code 8'hF1
  localparam logic [GW-1:0] GAIN_OFF = 8'h00;
  localparam logic [GW-1:0] GAIN_MIN = 8'h01;
  localparam logic [GW-1:0] GAIN_MAX = 8'hFF;
  localparam logic [GW-1:0] GAIN_UNITY = 8'hF1;
  localparam logic [4:0] PAN_MID = 5'h08;
  localparam logic [4:0] PAN_FULL = 5'h10;
  localparam logic [GW-1:0] PAN_CTR_ATT = 8'h04;
  localparam logic [SW-1:0] FS_POS = 24'h7F_FFFF;
  localparam logic [16:0] MANT [8] = '{17'h0_8000, 17'h0_8B96, 17'h0_9838, 17'h0_A5FF,
                                       17'h0_B505, 17'h0_C567, 17'h0_D745, 17'h0_EAC1};

  typedef enum logic {OP_GAIN, OP_GROUP} amm_op_e;
  typedef logic signed [SW-1:0] amm_smp_t;
  typedef struct packed {
    amm_op_e op;
    logic [5:0] src;
    logic [3:0] pair;
    logic [GW-1:0] val;
  } amm_cmd_s;
  typedef struct packed {
    logic mute;
    logic solo;
    logic trim;
    logic [4:0] pan;
  } amm_chan_s;

  function automatic logic signed [AW-1:0] amm_gain_mul(input logic signed [AW-1:0] x,
                                                        input logic [GW-1:0] code);
    logic [GW-1:0] e;
    logic signed [63:0] p;
    e = code - GAIN_MIN;
    p = 64'(x) * 64'(signed'({1'b0, MANT[e[2:0]]}));
    p = p >>> (UNITY_SHIFT - int'(e[7:3]));
    return (code == GAIN_OFF) ? '0 : p[AW-1:0];
  endfunction : amm_gain_mul

  // distance 0 means the source sits fully on this side
  function automatic logic [GW-1:0] amm_pan_att(input logic [4:0] d);
    if (d >= PAN_FULL) return GAIN_MAX;
    if (d <= PAN_MID) return GW'(d >> 1);
    return PAN_CTR_ATT + GW'((d - PAN_MID) << 2);
  endfunction : amm_pan_att

  function automatic logic [SW-1:0] amm_isqrt(input logic [2*SW-1:0] v);
    logic [SW-1:0] root;
    logic [SW-1:0] t;
    root = '0;
    for (int i = SW - 1; i >= 0; i--) begin
      t = root | (SW'(1) << i);
      if ((2*SW)'(t) * (2*SW)'(t) <= v) root = t;
    end
    return root;
  endfunction : amm_isqrt
endpackage : amm_pkg

// *** tb/amm_src_model.sv ***
// source model: converter and host playback frames toward the mixer
`timescale 1ns/1ps
module amm_src_model
  import amm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic send,
  input wire amm_smp_t [N_HW-1:0] hw_val,
  input wire amm_smp_t [N_PB-1:0] pb_val,
  output logic smp_valid,
  output amm_smp_t [N_HW-1:0] hw_in,
  output amm_smp_t [N_PB-1:0] pb_in
);
  initial begin
    smp_valid = 1'b0;
    hw_in = '0;
    pb_in = '0;
  end

  // outside the valid cycle the lines toggle, so a late capture in the mixer shows up
  always @(negedge clk_sys) begin
    smp_valid <= send;
    hw_in <= send ? hw_val : ~hw_in;
    pb_in <= send ? pb_val : ~pb_in;
  end
endmodule : amm_src_model

// *** tb/amm_mixer_bench.sv ***
// bench: gain rows, then over flag, mute, trim, level, reset, meter and group cases
`timescale 1ns/1ps
module amm_mixer_bench
  import amm_pkg::*;
;
  typedef struct packed {
    logic [5:0] src;
    logic [3:0] pair;
    logic [GW-1:0] val;
    logic [SW-1:0] a0;
    logic [SW-1:0] a1;
    logic [SW-1:0] p0;
  } amm_row_s;

  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic send = 1'b0;
  amm_smp_t [N_HW-1:0] hwv = '0;
  amm_smp_t [N_PB-1:0] pbv = '0;
  logic smp_valid;
  amm_smp_t [N_HW-1:0] hw_in;
  amm_smp_t [N_PB-1:0] pb_in;
  amm_chan_s [N_SRC-1:0] chan_cfg = '0;
  logic [N_SRC/2-1:0] stereo_src = '0;
  logic [N_OUT-1:0][GW-1:0] out_level = {N_OUT{GAIN_UNITY}};
  logic [N_OUT-1:0] loopback = '0;
  logic cmd_valid = 1'b0;
  amm_cmd_s cmd = '0;
  logic cmd_ready, cmd_ack, out_valid, rec_valid, level_valid;
  logic [GW-1:0] ctrl_gain;
  amm_smp_t [N_OUT-1:0] out_data;
  amm_smp_t [N_HW-1:0] rec_data;
  logic [5:0] meter_sel = '0;
  logic meter_rms = 1'b0;
  logic [N_MET-1:0] ovr_clear = '0;
  logic [SW-1:0] level;
  logic [N_MET-1:0] overload_indicator;
  int fail_count = 0;
  int tests_run = 0;
  int n;
  logic [GW-1:0] g [N_SRC][N_PAIR] = '{default: '0};
  logic [GW-1:0] olv [N_OUT];
  logic [SW-1:0] pk_max = '0;
  amm_row_s rows [6] = '{
    '{6'h00, 4'h0, 8'hF1, 24'h00_1000, 24'h00_0000, 24'h00_0000},
    '{6'h00, 4'h1, 8'hE9, 24'h00_1000, 24'h00_0000, 24'h00_0000},
    '{6'h12, 4'h2, 8'hF9, 24'h00_1000, 24'h00_0000, 24'h00_0300},
    '{6'h01, 4'h0, 8'hF1, 24'h00_1000, 24'h00_2000, 24'h00_0300},
    '{6'h01, 4'h0, 8'hF9, 24'h40_0000, 24'h40_0000, 24'h00_0300},
    '{6'h01, 4'h0, 8'hF9, 24'hC0_0000, 24'hC0_0000, 24'hFF_FD00}};

  always #50 clk_sys = ~clk_sys;

  amm_src_model i_amm_src_model (.clk_sys(clk_sys), .send(send), .hw_val(hwv), .pb_val(pbv),
    .smp_valid(smp_valid), .hw_in(hw_in), .pb_in(pb_in));

  amm_mixer #(.REFRESH_CYCLES(20), .RMS_K(2)) i_amm_mixer (.clk_sys, .rst_n, .smp_valid, .hw_in, .pb_in,
    .chan_cfg, .stereo_src, .out_level, .loopback, .cmd_valid, .cmd, .cmd_ready, .cmd_ack, .ctrl_gain,
    .out_data, .out_valid, .rec_data, .rec_valid, .meter_sel, .meter_rms, .ovr_clear, .level,
    .level_valid, .overload_indicator);

  // largest readout seen since the last frame start; sampled at posedge to stay clear of drive edges
  always @(posedge clk_sys) begin
    if (level_valid === 1'b1 && level > pk_max) pk_max = level;
  end

  task automatic check(input string what, input logic [SW-1:0] seen, input logic [SW-1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // only codes a whole number of 6 dB steps from unity are used, so the gain is an exact shift
  function automatic longint gmul(input longint x, input logic [GW-1:0] c);
    int sh;
    sh = (int'(c) - int'(GAIN_UNITY)) / 8;
    if (c == GAIN_OFF) return 0;
    return (sh >= 0) ? x <<< sh : x >>> (-sh);
  endfunction : gmul

  // pan 0 is fully left, full code fully right; centre is 3 dB down as 181/256, exact for the samples used
  function automatic logic [SW-1:0] exp_out(input int o);
    longint acc;
    longint v;
    bit solo_on;
    int b;
    acc = 0;
    solo_on = 1'b0;
    for (int s = 0; s < N_SRC; s++) solo_on |= chan_cfg[s].solo;
    for (int s = 0; s < N_SRC; s++) begin
      b = stereo_src[s / 2] ? s - s % 2 : s;
      v = gmul((s < N_HW) ? longint'(hwv[s]) : longint'(pbv[s - N_HW]), g[b][o / 2]);
      if (chan_cfg[b].pan == PAN_MID) v = v * 181 / 256;
      else if ((chan_cfg[b].pan == PAN_FULL) == (o % 2 == 0)) v = 0;
      if (stereo_src[s / 2] && s % 2 != o % 2) v = 0;
      if (chan_cfg[b].mute || (solo_on && !chan_cfg[b].solo)) v = 0;
      acc += v;
    end
    acc = gmul(acc, olv[o]);
    if (acc > longint'(24'sh7F_FFFF)) acc = longint'(24'sh7F_FFFF);
    if (acc < longint'(24'sh80_0000)) acc = longint'(24'sh80_0000);
    return acc[SW-1:0];
  endfunction : exp_out

  task automatic do_cmd(input amm_op_e op, input int src, input int pair, input logic [GW-1:0] val);
    n = 0;
    while (cmd_ready !== 1'b1 && n < 2000) begin
      @(negedge clk_sys);
      n++;
    end
    cmd_valid = 1'b1;
    cmd = '{op, 6'(src), 4'(pair), val};
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (cmd_ack !== 1'b1 && n < 2000);
    cmd_valid = 1'b0;
    check("cmd latency", SW'(n), 24'h00_014E);
  endtask : do_cmd

  // late0 is applied just after the start edge; dup sends a second frame in mid-mix
  task automatic frame(input logic [SW-1:0] a0, input logic [SW-1:0] a1, input logic [SW-1:0] p0,
                       input logic [GW-1:0] late0, input bit dup);
    hwv = '0;
    pbv = '0;
    hwv[0] = a0;
    hwv[1] = a1;
    pbv[0] = p0;
    pk_max = '0;
    for (int o = 0; o < N_OUT; o++) olv[o] = out_level[o];
    send <= 1'b1;
    @(negedge clk_sys);
    send <= 1'b0;
    @(negedge clk_sys);
    out_level[0] = late0;
    n = 1;
    while (out_valid !== 1'b1 && n < 2000) begin
      if (dup && n == 100) send <= 1'b1;
      if (dup && n == 101) send <= 1'b0;
      @(negedge clk_sys);
      n++;
    end
    check("frame latency", SW'(n), 24'h00_029B);
    check("record valid", SW'(rec_valid), 24'h00_0001);
    for (int o = 0; o < N_OUT; o++) check("out data", out_data[o], exp_out(o));
    for (int i = 0; i < N_HW; i++) check("rec data", rec_data[i], loopback[i] ? exp_out(i) : hwv[i]);
    if (dup) begin
      n = 0;
      repeat (700) begin
        @(negedge clk_sys);
        n += int'(out_valid === 1'b1);
      end
      check("dropped frame", SW'(n), 24'h00_0000);
    end
  endtask : frame

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out

  initial begin
    #8_000_000;
    fail_count++;
    close_out();
  end

  initial begin
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    foreach (rows[r]) begin
      do_cmd(OP_GAIN, rows[r].src, rows[r].pair, rows[r].val);
      g[rows[r].src][rows[r].pair] = rows[r].val;
      frame(rows[r].a0, rows[r].a1, rows[r].p0, GAIN_UNITY, 1'b0);
      $display("row %0d done", r);
    end
    check("over out", SW'(overload_indicator[N_SRC]), 24'h00_0001);
    check("over src", SW'(overload_indicator[0]), 24'h00_0000);
    ovr_clear[N_SRC] = 1'b1;
    @(negedge clk_sys);
    ovr_clear[N_SRC] = 1'b0;
    @(negedge clk_sys);
    check("over clear", SW'(overload_indicator[N_SRC]), 24'h00_0000);
    $display("over flag done");
    chan_cfg[1].mute = 1'b1;
    loopback[0] = 1'b1;
    // trim is latched at a mix start, so it is armed before this frame
    chan_cfg[0].trim = 1'b1;
    frame(24'h00_1000, 24'h00_2000, 24'h00_0000, GAIN_UNITY, 1'b0);
    chan_cfg[1].mute = 1'b0;
    loopback[0] = 1'b0;
    $display("mute and loopback done");
    do_cmd(OP_GAIN, 0, 0, 8'hF9);
    check("trim display", ctrl_gain, 24'h00_00F9);
    g[0][0] = 8'hF9;
    g[0][1] = 8'hF1;
    frame(24'h00_1000, 24'h00_0000, 24'h00_0000, GAIN_UNITY, 1'b0);
    chan_cfg[0].trim = 1'b0;
    $display("trim done");
    out_level[0] = 8'hE9;
    frame(24'h00_1000, 24'h00_0000, 24'h00_0000, GAIN_UNITY, 1'b1);
    $display("output level and refusal done");
    rst_n = 1'b0;
    @(negedge clk_sys);
    check("reset out", out_data[0], 24'h00_0000);
    check("reset over", SW'(|overload_indicator), 24'h00_0000);
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    g = '{default: '0};
    @(negedge clk_sys);
    check("ready after reset", SW'(cmd_ready), 24'h00_0001);
    $display("reset done");
    do_cmd(OP_GAIN, 0, 0, 8'hE9);
    g[0][0] = 8'hE9;
    frame(24'hFF_F000, 24'h00_0000, 24'h00_0000, GAIN_UNITY, 1'b0);
    repeat (45) @(negedge clk_sys);
    check("source peak", pk_max, 24'h00_1000);
    meter_sel = 6'h24;
    frame(24'hFF_F000, 24'h00_0000, 24'h00_0000, GAIN_UNITY, 1'b0);
    repeat (45) @(negedge clk_sys);
    check("output peak", pk_max, 24'h00_0800);
    meter_sel = 6'h01;
    meter_rms = 1'b1;
    frame(24'h00_0000, 24'h00_1000, 24'h00_0000, GAIN_UNITY, 1'b0);
    repeat (45) @(negedge clk_sys);
    check("rms level", pk_max, 24'h00_0800);
    n = 0;
    while (level_valid !== 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (level_valid !== 1'b1 && n < 100);
    check("refresh period", SW'(n), 24'h00_0014);
    $display("meters done");
    do_cmd(OP_GROUP, 0, 0, 8'h01);
    do_cmd(OP_GAIN, 1, 1, 8'hF1);
    do_cmd(OP_GROUP, 1, 1, 8'h01);
    do_cmd(OP_GAIN, 0, 0, 8'hF1);
    g[0][0] = 8'hF1;
    g[1][1] = 8'hF9;
    frame(24'h00_1000, 24'h00_0100, 24'h00_0000, GAIN_UNITY, 1'b0);
    $display("group done");
    chan_cfg[0].pan = PAN_MID;
    chan_cfg[0].solo = 1'b1;
    stereo_src[0] = 1'b1;
    frame(24'h00_1000, 24'h00_0100, 24'h00_0000, GAIN_UNITY, 1'b0);
    check("pan centre", out_data[0], 24'h00_0B50);
    check("stereo right", out_data[1], 24'h00_00B5);
    $display("pan solo and stereo done");
    close_out();
  end
endmodule : amm_mixer_bench
